// File: hw/eao_regs.svh
// Register offsets, reset values and timing counts of the encoder axis option block.
// Assumes the includer compares offsets against an 8-bit register address.
`ifndef EAO_REGS_SVH
`define EAO_REGS_SVH
// ************************************************
// Register offsets (32-bit data, low bits used)
// ************************************************
`define EAO_A_ROUTE 8'h00
`define EAO_A_RATE 8'h01
`define EAO_A_CASCADE 8'h02
`define EAO_A_BW_EN 8'h03
`define EAO_A_IRQ_SEL 8'h04
`define EAO_A_WAIT 8'h05
`define EAO_A_ICR 8'h06
`define EAO_A_INT_STAT 8'h07
`define EAO_A_INT_MASK 8'h08
`define EAO_A_PRESET 8'h10
`define EAO_A_COUNT 8'h14
`define EAO_A_LATCH 8'h18
// ************************************************
// Field positions
// ************************************************
`define EAO_ICR_GATE_BIT 4
`define EAO_ICR_LATCH_BIT 5
`define EAO_ROUTE_POL_LSB 4
// ************************************************
// Reset values
// ************************************************
`define EAO_RST_ROUTE 8'h0F
`define EAO_RST_RATE 3'h0
`define EAO_RST_CASCADE 3'h0
`define EAO_RST_BW_EN 4'hF
`define EAO_RST_IRQ_SEL 3'h1
`define EAO_RST_WAIT 2'h2
// ************************************************
// Timing
// ************************************************
`define EAO_SYS_KHZ 20000
`define EAO_FS_MIN_KHZ 625
`define EAO_DIV_MAX (`EAO_SYS_KHZ / `EAO_FS_MIN_KHZ)
`define EAO_FILT_LEN 4
`define EAO_CNT_W 24
`endif

// File: hw/eao_pkg.sv
// Types shared by the encoder axis option block.
// Assumes nothing beyond a SystemVerilog compiler.
package eao_pkg;
  // Wait-state sequencer, one-hot
  typedef enum logic [2:0] {
    EAO_W_IDLE = 3'b001,
    EAO_W_WAIT = 3'b010,
    EAO_W_DONE = 3'b100
  } eao_wst_t;
  // One axis count word
  typedef logic [23:0] eao_cnt_t;
endpackage : eao_pkg

// File: hw/eao_axis_opt.sv
// Four-axis encoder counter option logic: filters, counters, index actions,
// cascading, borrow routing, request line choice and host wait states.
// Assumes encoder pins and the host cycle strobe are asynchronous to clk_sys_i.
// Functional notes
// - Gate select zero clears, one gates phases
// - Latch select zero presets, one latches count
// - Per-axis route: gate/clear or preset/latch
// - Index polarity selectable per axis
// - Five sample rates, slowest is default
// - Neighbour counters chain pairwise, default off
// - Borrow to interrupt connectable, default connected
// - Request on exactly one line, IRQ3 default
// - Zero, one or two wait states, two default
// - Indicator lit while encoder input low
// - Four-stage filter on every encoder input
// - Each axis holds a 24-bit counter
`include "eao_regs.svh"
module eao_axis_opt (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Encoder pins
  input wire logic [3:0] enc_a_i,
  input wire logic [3:0] enc_b_i,
  input wire logic [3:0] enc_idx_i,
  // Indicators and borrow outputs
  output logic [11:0] led_low_o,
  output logic [3:0] underflow_out_n_o,
  // Host side
  output logic [5:0] irq_req_o,
  input wire logic host_cycle_n_i,
  output logic host_ready_o
);
  import eao_pkg::*;

  // ************************************************
  // State
  // ************************************************
  logic [11:0] s1, s2; // Pin synchronisers
  logic [11:0] next_led; // Indicator next value
  logic [4:0] div_cnt, next_div_cnt; // Sample divider
  logic tick; // Sample clock enable pulse
  logic [`EAO_FILT_LEN-1:0] shf [12]; // Filter history
  logic [`EAO_FILT_LEN-1:0] next_shf [12];
  logic [11:0] filt, next_filt; // Filtered inputs
  logic [11:0] filt_q; // Previous filtered inputs
  logic [7:0] route; // [3:0] route, [7:4] polarity
  logic [2:0] rate, cascade, irq_sel;
  logic [3:0] bw_en;
  logic [1:0] wsel;
  logic [7:0] input_control_reg; // {latch, gate} per axis
  logic [7:0] int_stat, int_mask;
  eao_cnt_t preset [4];
  eao_cnt_t cnt [4];
  eao_cnt_t lat [4];
  eao_cnt_t next_cnt [4];
  eao_cnt_t next_lat [4];
  logic [3:0] cy, bw, qidx, qidx_q;
  logic [3:0] next_ufl;
  logic [7:0] next_stat;
  logic [31:0] next_rdata;
  logic hc1, hc2, hc_q; // Host strobe sync
  eao_wst_t wst, next_wst;
  logic [1:0] wcnt, next_wcnt;
  logic [1:0] wlim;

  // ************************************************
  // Sample clock and filters
  // ************************************************
  // Divider mask shrinks by one bit per faster rate step
  always_comb begin
    logic [4:0] mask;
    mask = 5'(`EAO_DIV_MAX - 1) >> rate;
    tick = (div_cnt & mask) == mask;
    next_div_cnt = div_cnt + 5'h01;
    next_led = ~s2;
    for (int i = 0; i < 12; i++) begin
      next_shf[i] = shf[i];
      next_filt[i] = filt[i];
      if (tick) begin
        next_shf[i] = {shf[i][`EAO_FILT_LEN-2:0], s2[i]};
        // Output moves only after four equal samples
        if (&next_shf[i]) begin
          next_filt[i] = 1'b1;
        end else if (~|next_shf[i]) begin
          next_filt[i] = 1'b0;
        end
      end
    end
  end

  // Synchronisers, filter and indicator registers
  always_ff @(posedge clk_sys_i) begin
    s1 <= {enc_idx_i, enc_b_i, enc_a_i};
    s2 <= s1;
    if (srst_i) begin
      div_cnt <= 5'h00;
      led_low_o <= 12'h000;
      // Index lines start at their idle high level, so no false index follows
      filt <= 12'hF00;
      filt_q <= 12'hF00;
      for (int i = 0; i < 12; i++) begin
        shf[i] <= (i >= 8) ? 4'hF : 4'h0;
      end
    end else begin
      div_cnt <= next_div_cnt;
      led_low_o <= next_led;
      filt <= next_filt;
      filt_q <= filt;
      for (int i = 0; i < 12; i++) begin
        shf[i] <= next_shf[i];
      end
    end
  end

  // ************************************************
  // Counters and index actions
  // ************************************************
  // Decode, cascade ripple and index actions per axis
  always_comb begin
    logic step, up, inc, dec, gate_sel, lat_sel, gate_ok;
    step = 1'b0;
    up = 1'b0;
    inc = 1'b0;
    dec = 1'b0;
    gate_sel = 1'b0;
    lat_sel = 1'b0;
    gate_ok = 1'b0;
    for (int a = 0; a < 4; a++) begin
      // Active level after polarity, filtered copy only
      qidx[a] = filt[8+a] ^ ~route[`EAO_ROUTE_POL_LSB+a];
      gate_sel = input_control_reg[2*a+`EAO_ICR_GATE_BIT-4];
      lat_sel = input_control_reg[2*a+`EAO_ICR_LATCH_BIT-4];
      gate_ok = route[a] | ~gate_sel | qidx[a];
      step = filt[a] ^ filt_q[a] ^ filt[4+a] ^ filt_q[4+a];
      up = filt[a] ^ filt_q[4+a];
      if (a > 0 && cascade[a-1]) begin
        inc = cy[a-1];
        dec = bw[a-1];
      end else begin
        inc = step & up & gate_ok;
        dec = step & ~up & gate_ok;
      end
      cy[a] = inc & (cnt[a] == 24'hFFFFFF);
      bw[a] = dec & (cnt[a] == 24'h000000);
      next_cnt[a] = cnt[a];
      next_lat[a] = lat[a];
      if (inc) begin
        next_cnt[a] = cnt[a] + 24'h000001;
      end else if (dec) begin
        next_cnt[a] = cnt[a] - 24'h000001;
      end
      if (qidx[a]) begin
        if (!route[a] && !gate_sel) begin
          next_cnt[a] = 24'h000000;
        end else if (route[a] && !lat_sel) begin
          next_cnt[a] = preset[a];
        end else if (route[a]) begin
          next_lat[a] = cnt[a];
        end
      end
      next_ufl[a] = ~bw[a];
    end
  end

  // Counter, latch and borrow registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      qidx_q <= 4'h0;
      underflow_out_n_o <= 4'hF;
      for (int a = 0; a < 4; a++) begin
        cnt[a] <= 24'h000000;
        lat[a] <= 24'h000000;
      end
    end else begin
      qidx_q <= qidx;
      underflow_out_n_o <= next_ufl;
      for (int a = 0; a < 4; a++) begin
        cnt[a] <= next_cnt[a];
        lat[a] <= next_lat[a];
      end
    end
  end

  // ************************************************
  // Register port and interrupts
  // ************************************************
  // Sticky status: set wins over write-one clear
  always_comb begin
    next_stat = int_stat;
    if (reg_wr_i && reg_addr_i == `EAO_A_INT_STAT) begin
      next_stat = int_stat & ~reg_wdata_i[7:0];
    end
    next_stat[3:0] = next_stat[3:0] | (qidx & ~qidx_q);
    next_stat[7:4] = next_stat[7:4] | (bw & bw_en);
    next_rdata = 32'h00000000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `EAO_A_ROUTE: next_rdata = {24'h000000, route};
        `EAO_A_RATE: next_rdata = {29'h00000000, rate};
        `EAO_A_CASCADE: next_rdata = {29'h00000000, cascade};
        `EAO_A_BW_EN: next_rdata = {28'h0000000, bw_en};
        `EAO_A_IRQ_SEL: next_rdata = {29'h00000000, irq_sel};
        `EAO_A_WAIT: next_rdata = {30'h00000000, wsel};
        `EAO_A_ICR: next_rdata = {24'h000000, input_control_reg};
        `EAO_A_INT_STAT: next_rdata = {24'h000000, int_stat};
        `EAO_A_INT_MASK: next_rdata = {24'h000000, int_mask};
        default: begin
          // Per-axis words; unmapped reads zero
          if (reg_addr_i[7:2] == 6'(`EAO_A_PRESET >> 2)) begin
            next_rdata = {8'h00, preset[reg_addr_i[1:0]]};
          end else if (reg_addr_i[7:2] == 6'(`EAO_A_COUNT >> 2)) begin
            next_rdata = {8'h00, cnt[reg_addr_i[1:0]]};
          end else if (reg_addr_i[7:2] == 6'(`EAO_A_LATCH >> 2)) begin
            next_rdata = {8'h00, lat[reg_addr_i[1:0]]};
          end
        end
      endcase
    end
  end

  // Configuration, status and read data registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      route <= `EAO_RST_ROUTE;
      rate <= `EAO_RST_RATE;
      cascade <= `EAO_RST_CASCADE;
      bw_en <= `EAO_RST_BW_EN;
      irq_sel <= `EAO_RST_IRQ_SEL;
      wsel <= `EAO_RST_WAIT;
      input_control_reg <= 8'h00;
      int_stat <= 8'h00;
      int_mask <= 8'h00;
      reg_rdata_o <= 32'h00000000;
      irq_req_o <= 6'h00;
      for (int a = 0; a < 4; a++) begin
        preset[a] <= 24'h000000;
      end
    end else begin
      int_stat <= next_stat;
      reg_rdata_o <= next_rdata;
      // One line only, chosen by irq_sel
      irq_req_o <= (|(int_stat & int_mask)) ? 6'(6'h01 << irq_sel) : 6'h00;
      if (reg_wr_i) begin
        unique case (reg_addr_i)
          `EAO_A_ROUTE: route <= reg_wdata_i[7:0];
          `EAO_A_RATE: rate <= (reg_wdata_i[2:0] > 3'h4) ? 3'h4 : reg_wdata_i[2:0];
          `EAO_A_CASCADE: cascade <= reg_wdata_i[2:0];
          `EAO_A_BW_EN: bw_en <= reg_wdata_i[3:0];
          `EAO_A_IRQ_SEL: irq_sel <= (reg_wdata_i[2:0] > 3'h5) ? 3'h5 : reg_wdata_i[2:0];
          `EAO_A_WAIT: wsel <= (reg_wdata_i[1:0] == 2'h3) ? 2'h2 : reg_wdata_i[1:0];
          `EAO_A_ICR: input_control_reg <= reg_wdata_i[7:0];
          `EAO_A_INT_MASK: int_mask <= reg_wdata_i[7:0];
          default: begin
            // Preset words
            if (reg_addr_i[7:2] == 6'(`EAO_A_PRESET >> 2)) begin
              preset[reg_addr_i[1:0]] <= reg_wdata_i[23:0];
            end
          end
        endcase
      end
    end
  end

  // ************************************************
  // Host wait states
  // ************************************************
  // Ready drops for wsel cycles from the cycle start
  always_comb begin
    wlim = wsel;
    next_wst = wst;
    next_wcnt = wcnt;
    unique case (wst)
      EAO_W_IDLE: begin
        if (!hc2 && hc_q && wlim != 2'h0) begin
          next_wst = EAO_W_WAIT;
          next_wcnt = 2'h1;
        end
      end
      EAO_W_WAIT: begin
        if (wcnt == wlim) begin
          next_wst = EAO_W_DONE;
        end else begin
          next_wcnt = wcnt + 2'h1;
        end
      end
      EAO_W_DONE: begin
        // Wait for host to end its cycle
        if (hc2) begin
          next_wst = EAO_W_IDLE;
        end
      end
      default: next_wst = EAO_W_IDLE;
    endcase
  end

  // Strobe sync and sequencer registers
  always_ff @(posedge clk_sys_i) begin
    hc1 <= host_cycle_n_i;
    hc2 <= hc1;
    if (srst_i) begin
      hc_q <= 1'b1;
      wst <= EAO_W_IDLE;
      wcnt <= 2'h0;
    end else begin
      hc_q <= hc2;
      wst <= next_wst;
      wcnt <= next_wcnt;
    end
  end

  assign host_ready_o = (wst != EAO_W_WAIT);

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  property p_clear;
    !route[0] && !input_control_reg[0] && qidx[0] |=> cnt[0] == 24'h000000;
  endproperty
  a_clear: assert property (p_clear) else $error("index clear missed");
  property p_gate;
    !route[0] && input_control_reg[0] && !qidx[0] |=> $stable(cnt[0]);
  endproperty
  a_gate: assert property (p_gate) else $error("gated counter moved");
  property p_load;
    route[0] && !input_control_reg[1] && qidx[0] |=> cnt[0] == $past(preset[0]);
  endproperty
  a_load: assert property (p_load) else $error("preset load missed");
  property p_latch;
    route[0] && input_control_reg[1] && qidx[0] |=> lat[0] == $past(cnt[0]);
  endproperty
  a_latch: assert property (p_latch) else $error("latch capture missed");
  property p_irq_one;
    $onehot0(irq_req_o);
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("more than one request line");
  property p_wait2;
    wsel == 2'h2 && $fell(host_ready_o) |-> !host_ready_o ##1 !host_ready_o ##1 host_ready_o;
  endproperty
  a_wait2: assert property (p_wait2) else $error("wait length wrong");
  property p_led;
    ##3 1'b1 |-> led_low_o[3:0] == ~$past(enc_a_i, 3);
  endproperty
  a_led: assert property (p_led) else $error("indicator wrong");
  property p_filt;
    $changed(filt) |-> $past(tick);
  endproperty
  a_filt: assert property (p_filt) else $error("filter moved off tick");
  property p_bw;
    !underflow_out_n_o[1] |-> $past(cnt[1]) == 24'h000000 && cnt[1] == 24'hFFFFFF;
  endproperty
  a_bw: assert property (p_bw) else $error("borrow without underflow");
  property p_bw_iso;
    bw[1] && !bw_en[1] && !int_stat[5] |=> !int_stat[5];
  endproperty
  a_bw_iso: assert property (p_bw_iso) else $error("isolated borrow raised status");
endmodule : eao_axis_opt

// File: tb/eao_enc_host_model.sv
// Behavioural encoders and host bus cycle for the axis option bench.
// Assumes the bench calls these tasks one at a time from one process.
module eao_enc_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Encoder pins
  output logic [3:0] enc_a_o,
  output logic [3:0] enc_b_o,
  output logic [3:0] enc_idx_o,
  // Host cycle
  output logic host_cycle_n_o,
  input wire logic host_ready_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Pin state
  // ****************
  // Quadrature position of each axis
  logic [1:0] pos [4];
  // Idle pins: phases low, index inactive high
  initial begin
    enc_a_o = 4'h0;
    enc_b_o = 4'h0;
    enc_idx_o = 4'hF;
    host_cycle_n_o = 1'b1;
    for (int i = 0; i < 4; i++) pos[i] = 2'h0;
  end
  // ****************
  // Tasks
  // ****************
  // One quadrature step, A leading B counts up; settles past the filter at rate 4 only
  task automatic step(input int ax, input bit up);
    @(posedge clk_sys_i);
    pos[ax] = up ? pos[ax] + 2'h1 : pos[ax] - 2'h1;
    enc_a_o[ax] <= (pos[ax] == 2'h1) || (pos[ax] == 2'h2);
    enc_b_o[ax] <= pos[ax][1];
    repeat (16) @(posedge clk_sys_i);
  endtask : step
  // Active-low index pulse lasting len clocks
  task automatic idx(input int ax, input int len);
    @(posedge clk_sys_i);
    enc_idx_o[ax] <= 1'b0;
    repeat (len) @(posedge clk_sys_i);
    enc_idx_o[ax] <= 1'b1;
    repeat (16) @(posedge clk_sys_i);
  endtask : idx
  // Host access held open across every wait state the card asks for
  task automatic host_rw(output int n_wait);
    n_wait = 0;
    @(posedge clk_sys_i);
    host_cycle_n_o <= 1'b0;
    repeat (10) begin
      @(posedge clk_sys_i);
      if (host_ready_i !== 1'b1) n_wait++;
    end
    host_cycle_n_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask : host_rw
endmodule : eao_enc_host_model

// File: tb/encoder_axis_option_logic_tb_top.sv
// Self-checking bench of the encoder axis option block.
// Assumes eao_regs.svh on the include path and the partner model compiled.
`include "eao_regs.svh"
module encoder_axis_option_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import eao_pkg::*;
  // Clock, reset and register port
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  // Pins and outputs
  logic [3:0] enc_a, enc_b, enc_idx, underflow_out_n_o;
  logic [11:0] led_low_o;
  logic [5:0] irq_req_o;
  logic host_cycle_n, host_ready_o;
  // Tallies
  int n_errors = 0;
  int total_checks = 0;
  // Sticky record of borrow output pulses, one bit per axis
  logic [3:0] ufl_seen = 4'h0;
  // 20 MHz clock
  always #25 clk_sys_i = ~clk_sys_i;
  // Collect every low pulse on the borrow outputs once out of reset
  always @(posedge clk_sys_i) begin
    if (!srst_i) ufl_seen <= ufl_seen | ~underflow_out_n_o;
  end
  // ****************
  // Instances
  // ****************
  eao_axis_opt dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .enc_a_i(enc_a), .enc_b_i(enc_b), .enc_idx_i(enc_idx),
    .led_low_o(led_low_o), .underflow_out_n_o(underflow_out_n_o), .irq_req_o(irq_req_o),
    .host_cycle_n_i(host_cycle_n), .host_ready_o(host_ready_o));
  eao_enc_host_model m (.clk_sys_i(clk_sys_i), .enc_a_o(enc_a), .enc_b_o(enc_b),
    .enc_idx_o(enc_idx), .host_cycle_n_o(host_cycle_n), .host_ready_i(host_ready_o));
  // ****************
  // Helpers
  // ****************
  // Compare and count
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One-cycle register write
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // One-cycle read, data judged in the following cycle
  task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk(what, reg_rdata_o, exp);
  endtask : rdc
  // Verdict and end of run
  task results;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // ****************
  // Scenarios
  // ****************
  // Shipped defaults and idle indicators
  task t_reset;
    chk("irq idle", 32'(irq_req_o), 32'h0);
    rdc("route", `EAO_A_ROUTE, 32'h0F);
    rdc("rate", `EAO_A_RATE, 32'h0);
    rdc("cascade", `EAO_A_CASCADE, 32'h0);
    rdc("borrow en", `EAO_A_BW_EN, 32'hF);
    rdc("irq sel", `EAO_A_IRQ_SEL, 32'h1);
    rdc("wait", `EAO_A_WAIT, 32'h2);
    rdc("unmapped", 8'h30, 32'h0);
    chk("led idle", 32'(led_low_o), 32'h0FF);
  endtask : t_reset
  // Every wait-state choice seen by the host
  task t_wait;
    int n;
    for (int w = 0; w < 3; w++) begin
      wr(`EAO_A_WAIT, 32'(w));
      m.host_rw(n);
      chk("wait states", 32'(n), 32'(w));
    end
  endtask : t_wait
  // Counting and all four index actions on axis 0
  task t_index;
    wr(`EAO_A_RATE, 32'h4);
    wr(`EAO_A_PRESET, 32'h123);
    m.step(0, 1'b1);
    chk("led phase", 32'(led_low_o), 32'h0FE);
    repeat (4) m.step(0, 1'b1);
    m.step(0, 1'b0);
    rdc("count", `EAO_A_COUNT, 32'h4);
    m.idx(0, 1);
    rdc("glitch", `EAO_A_COUNT, 32'h4);
    m.idx(0, 16);
    rdc("preset load", `EAO_A_COUNT, 32'h123);
    wr(`EAO_A_ICR, 32'h2);
    m.step(0, 1'b1);
    m.idx(0, 16);
    rdc("latch load", `EAO_A_LATCH, 32'h124);
    wr(`EAO_A_ROUTE, 32'h0E);
    wr(`EAO_A_ICR, 32'h0);
    m.idx(0, 16);
    rdc("clear", `EAO_A_COUNT, 32'h0);
    wr(`EAO_A_ICR, 32'h1);
    m.step(0, 1'b1);
    rdc("gate shut", `EAO_A_COUNT, 32'h0);
    wr(`EAO_A_ROUTE, 32'h1E);
    m.step(0, 1'b1);
    rdc("gate open", `EAO_A_COUNT, 32'h1);
  endtask : t_index
  // Request lines, mask, clear and borrow routing on axis 1
  task t_irq;
    wr(`EAO_A_INT_MASK, 32'hFF);
    wr(`EAO_A_INT_STAT, 32'hFF);
    m.idx(1, 16);
    rdc("index event", `EAO_A_INT_STAT, 32'h02);
    for (int k = 0; k < 6; k++) begin
      wr(`EAO_A_IRQ_SEL, 32'(k));
      repeat (2) @(posedge clk_sys_i);
      chk("irq line", 32'(irq_req_o), 32'h1 << k);
    end
    wr(`EAO_A_INT_MASK, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    chk("irq masked", 32'(irq_req_o), 32'h0);
    wr(`EAO_A_INT_MASK, 32'hFF);
    wr(`EAO_A_INT_STAT, 32'h02);
    repeat (2) @(posedge clk_sys_i);
    chk("irq cleared", 32'(irq_req_o), 32'h0);
    m.step(1, 1'b0);
    rdc("borrow event", `EAO_A_INT_STAT, 32'h20);
    chk("borrow pulse", 32'(ufl_seen), 32'h2);
    chk("borrow idle", 32'(underflow_out_n_o), 32'hF);
    rdc("wrap", `EAO_A_COUNT + 8'h01, 32'hFFFFFF);
    wr(`EAO_A_BW_EN, 32'hD);
    m.idx(1, 16);
    wr(`EAO_A_INT_STAT, 32'hFF);
    m.step(1, 1'b0);
    rdc("borrow isolated", `EAO_A_INT_STAT, 32'h0);
  endtask : t_irq
  // Axis 0 borrow ripples into axis 1 once the pair is chained
  task t_cascade;
    wr(`EAO_A_CASCADE, 32'h1);
    rdc("cascade set", `EAO_A_CASCADE, 32'h1);
    m.step(1, 1'b1);
    rdc("chained own input", `EAO_A_COUNT + 8'h01, 32'hFFFFFF);
    m.step(0, 1'b0);
    m.step(0, 1'b0);
    rdc("low word", `EAO_A_COUNT, 32'hFFFFFF);
    rdc("chained borrow", `EAO_A_COUNT + 8'h01, 32'hFFFFFE);
    chk("borrow pulses", 32'(ufl_seen), 32'h3);
    rdc("low borrow event", `EAO_A_INT_STAT, 32'h10);
    chk("irq borrow", 32'(irq_req_o), 32'h20);
  endtask : t_cascade
  // ****************
  // Sequence
  // ****************
  // Reset, scenarios, verdict
  initial begin
    repeat (12) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_reset;
    t_wait;
    t_index;
    t_irq;
    t_cascade;
    results;
  end
  // Hang guard
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    n_errors++;
    $display("Run cut short by the cycle limit");
    results;
  end
endmodule : encoder_axis_option_logic_tb_top
